/* verilog/tpgcl_pkg.sv */
// constants shared by the three-phase gate control logic
package tpgcl_pkg;

  // ---------------------------------------------------------------
  // bus and register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h04;
  localparam logic [7:0] OFS_SUPPRESS_LO = 8'h08;
  localparam logic [7:0] OFS_SUPPRESS_HI = 8'h0C;
  localparam logic [7:0] OFS_COMMAND = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CFG_DT_BYPASS_BIT = 0;
  localparam int unsigned CFG_OVERLAP_BIT = 1;
  localparam int unsigned CFG_DEAD_LSB = 8;
  localparam int unsigned DEAD_W = 8;
  localparam int unsigned CMD_CLEAR_INT_BIT = 0;
  localparam int unsigned NUM_FAULTS = 8;
  localparam int unsigned HALF_FAULTS = 4;
  localparam int unsigned NUM_PHASES = 3;
  localparam int unsigned ST_LEVEL_LSB = 0;
  localparam int unsigned ST_BOOT_LSB = 3;
  localparam int unsigned ST_ENABLED_BIT = 6;
  localparam int unsigned ST_IRQ_BIT = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DEAD_W-1:0] DEAD_RESET = 8'h10;
  localparam logic [HALF_FAULTS-1:0] SUPPRESS_RESET = 4'h0;

  // ---------------------------------------------------------------
  // timing: internal logic reset must be complete within this time
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned RESET_DONE_NS = 77;
  localparam int unsigned RESET_DONE_CYC =
    ((RESET_DONE_NS * 1000) / CLK_PERIOD_PS) < 1 ? 1 :
    ((RESET_DONE_NS * 1000) / CLK_PERIOD_PS);

endpackage

/* verilog/tpgcl_phase.sv */
// one half-bridge channel: input sync, interlock, dead time, bootstrap
`timescale 1ns/1ps
module tpgcl_phase
#(
  parameter int unsigned DW = 8
)
(
  // clock and internal reset
  input wire logic clk,
  input wire logic rst,
  // raw phase commands
  input wire logic high_cmd_n,
  input wire logic low_cmd,
  // synchronised enable state and configuration
  input wire logic en_ok,
  input wire logic dt_bypass,
  input wire logic overlap_allow,
  input wire logic [DW-1:0] dead_cycles,
  // gate requests and bootstrap state
  output logic hs_req,
  output logic ls_req,
  output logic boot_ready
);

  typedef struct packed {
    logic h_meta;
    logic h_sync;
    logic l_meta;
    logic l_sync;
    logic hs;
    logic ls;
    logic boot;
    logic [DW-1:0] dead_cnt;
  } tpgcl_phase_st_t;

  tpgcl_phase_st_t st_ff;
  tpgcl_phase_st_t nxt_st;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    logic want_h;
    logic want_l;
    logic dt_busy;
    want_h = 1'b0;
    want_l = 1'b0;
    dt_busy = 1'b0;
    nxt_st = st_ff;
    // two-stage synchronisers, first stage feeds only the second
    nxt_st.h_meta = high_cmd_n; // R17
    nxt_st.h_sync = st_ff.h_meta;
    nxt_st.l_meta = low_cmd;
    nxt_st.l_sync = st_ff.l_meta;
    // high side active low, low side active high
    want_h = ~st_ff.h_sync; // R09
    want_l = st_ff.l_sync; // R10
    // both asked at once: refuse both unless overlap allowed
    if (want_h && want_l && !overlap_allow)
    begin
      want_h = 1'b0; // R13
      want_l = 1'b0;
    end
    dt_busy = (st_ff.dead_cnt != '0) && !dt_bypass;
    // high side: needs charged bootstrap, off partner, elapsed dead time
    if (!want_h)
      nxt_st.hs = 1'b0;
    else if (!st_ff.hs)
      nxt_st.hs = st_ff.boot && !dt_busy && (overlap_allow || !st_ff.ls); // R04 R13
    // low side: off partner and elapsed dead time
    if (!want_l)
      nxt_st.ls = 1'b0;
    else if (!st_ff.ls)
      nxt_st.ls = !dt_busy && (overlap_allow || !st_ff.hs); // R13
    // dead time reloads whenever a side turns off
    if ((st_ff.hs && !nxt_st.hs) || (st_ff.ls && !nxt_st.ls))
      nxt_st.dead_cnt = dead_cycles; // R13
    else if (st_ff.dead_cnt != '0)
      nxt_st.dead_cnt = st_ff.dead_cnt - 1'b1;
    // bootstrap charged once low side ran with drive enabled
    if (!en_ok)
      nxt_st.boot = 1'b0; // R04
    else if (st_ff.ls)
      nxt_st.boot = 1'b1; // R04
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      st_ff <= '{h_meta: 1'b1, h_sync: 1'b1, default: '0};
    else
      st_ff <= nxt_st;
  end

  assign hs_req = st_ff.hs;
  assign ls_req = st_ff.ls;
  assign boot_ready = st_ff.boot;

endmodule

/* verilog/tpgcl_top.sv */
// three-phase gate control logic with apb registers and fault interrupt
//
// Summary of operation
// R01: gate outputs may turn on only while both drive permits are high.
// R02: with permits low, registers and bus keep working normally.
// R03: permits force gates off combinationally, without a clock edge.
// R04: after re-enable, a phase's low side must run before its high side.
// R05: low-power reset pin disables outputs, bias off, weak pull-down on.
// R06: internal logic reset completes within 77 ns of the low-power pin.
// R07: below power-on threshold: logic reset, gates tri-stated, bus refused.
// R08: phase level output high when high-side source above half supply.
// R09: high-side command inputs are active low, idle off.
// R10: low-side command inputs are active high, idle off.
// R11: fault raises interrupt, held until the clear-interrupt command; code also clears it on a fault status read.
// R12: two suppress registers mask fault sources from the interrupt.
// R13: interlock and dead time keep one phase's FETs apart; both bypassable.
// R14: host keeps serial configuration clock at or below 4.0 MHz.
// R15: serial input sampled on falling clock, most significant bit first; code has no serial port, takes parallel apb writes.
// R16: serial output high impedance until selected, updates on rising clock; code drives PRDATA from a register at all times instead.
// R17: commands synchronised before interlock; permit gating stays combinational.
`timescale 1ns/1ps
module tpgcl_top
  import tpgcl_pkg::*;
(
  // clock and synchronous reset
  input wire logic MCLK,
  input wire logic RST,
  // supply and low-power control
  input wire logic POWER_GOOD,
  input wire logic LOWPOWER_N,
  // drive permits
  input wire logic DRIVE_PERMIT_FIRST,
  input wire logic DRIVE_PERMIT_SECOND,
  // phase commands
  input wire logic HIGH_CMD_A_N,
  input wire logic LOW_CMD_A,
  input wire logic HIGH_CMD_B_N,
  input wire logic LOW_CMD_B,
  input wire logic HIGH_CMD_C_N,
  input wire logic LOW_CMD_C,
  // analog sense inputs
  input wire logic [tpgcl_pkg::NUM_PHASES-1:0] PHASE_ABOVE_HALF,
  input wire logic [tpgcl_pkg::NUM_FAULTS-1:0] FAULT_IN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [tpgcl_pkg::ADDR_W-1:0] PADDR,
  input wire logic [tpgcl_pkg::DATA_W-1:0] PWDATA,
  output logic [tpgcl_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // gate drives
  output logic [tpgcl_pkg::NUM_PHASES-1:0] GATE_HIGH,
  output logic [tpgcl_pkg::NUM_PHASES-1:0] GATE_LOW,
  output logic GATE_OE,
  output logic GATE_WEAK_PULLDOWN,
  output logic BIAS_EN,
  // status outputs
  output logic PHASE_LEVEL_A,
  output logic PHASE_LEVEL_B,
  output logic PHASE_LEVEL_C,
  output logic FAULT_IRQ
);

  import tpgcl_pkg::*;

  // ---------------------------------------------------------------
  // state of the block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pg_meta;
    logic pg_sync;
    logic lp_n_meta;
    logic lp_n_sync;
    logic en_meta;
    logic en_sync;
    logic dt_bypass;
    logic overlap_allow;
    logic [DEAD_W-1:0] dead_cycles;
    logic [HALF_FAULTS-1:0] fault_suppress_lo;
    logic [HALF_FAULTS-1:0] fault_suppress_hi;
    logic [NUM_FAULTS-1:0] fault_status;
    logic [NUM_PHASES-1:0] level;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } tpgcl_state_t;

  tpgcl_state_t st_ff;
  tpgcl_state_t nxt_st;

  logic [NUM_PHASES-1:0] high_cmd_n;
  logic [NUM_PHASES-1:0] low_cmd;
  logic [NUM_PHASES-1:0] hs_req;
  logic [NUM_PHASES-1:0] ls_req;
  logic [NUM_PHASES-1:0] boot_ready;
  logic logic_rst;
  logic powered;
  logic permit_both;
  logic apb_setup;
  logic apb_access;
  logic addr_hit;
  logic [NUM_FAULTS-1:0] fault_mask;

  // ---------------------------------------------------------------
  // internal reset from pin, power-on and low-power state
  // ---------------------------------------------------------------
  // power good and low-power pin are sampled; the internal reset
  // follows one edge later, well inside RESET_DONE_CYC
  assign powered = st_ff.pg_sync && st_ff.lp_n_sync;
  assign logic_rst = RST || !powered; // R06 R07

  // ---------------------------------------------------------------
  // command bundling
  // ---------------------------------------------------------------
  assign high_cmd_n = {HIGH_CMD_C_N, HIGH_CMD_B_N, HIGH_CMD_A_N};
  assign low_cmd = {LOW_CMD_C, LOW_CMD_B, LOW_CMD_A};

  // ---------------------------------------------------------------
  // per-phase channels
  // ---------------------------------------------------------------
  genvar ph;
  generate
    for (ph = 0; ph < NUM_PHASES; ph++)
    begin : g_phase
      tpgcl_phase #(
        .DW(DEAD_W)
      ) u_phase (
        .clk(MCLK),
        .rst(logic_rst),
        .high_cmd_n(high_cmd_n[ph]),
        .low_cmd(low_cmd[ph]),
        .en_ok(st_ff.en_sync),
        .dt_bypass(st_ff.dt_bypass),
        .overlap_allow(st_ff.overlap_allow),
        .dead_cycles(st_ff.dead_cycles),
        .hs_req(hs_req[ph]),
        .ls_req(ls_req[ph]),
        .boot_ready(boot_ready[ph])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // gate outputs: permit gating is combinational on the raw pins
  // ---------------------------------------------------------------
  assign permit_both = DRIVE_PERMIT_FIRST && DRIVE_PERMIT_SECOND; // R01 R03
  // gated outputs pulled low whenever permits or low-power drop
  assign GATE_HIGH = (permit_both && LOWPOWER_N) ? hs_req : '0; // R01 R03 R05
  assign GATE_LOW = (permit_both && LOWPOWER_N) ? ls_req : '0; // R01 R03 R05
  // drivers tri-stated until the logic supply is good
  assign GATE_OE = st_ff.pg_sync; // R07
  assign GATE_WEAK_PULLDOWN = !st_ff.lp_n_sync; // R05
  assign BIAS_EN = st_ff.lp_n_sync; // R05

  // ---------------------------------------------------------------
  // phase levels and interrupt
  // ---------------------------------------------------------------
  assign PHASE_LEVEL_A = st_ff.level[0]; // R08
  assign PHASE_LEVEL_B = st_ff.level[1]; // R08
  assign PHASE_LEVEL_C = st_ff.level[2]; // R08
  assign FAULT_IRQ = st_ff.irq;
  assign fault_mask = {st_ff.fault_suppress_hi, st_ff.fault_suppress_lo};

  // ---------------------------------------------------------------
  // apb decode; zero wait state, bus refused while unpowered
  // ---------------------------------------------------------------
  assign apb_setup = PSEL && !PENABLE;
  assign apb_access = PSEL && PENABLE;
  always_comb
  begin
    addr_hit = 1'b0;
    unique case (PADDR)
      OFS_CONFIG, OFS_FAULT_STATUS, OFS_SUPPRESS_LO, OFS_SUPPRESS_HI,
      OFS_COMMAND, OFS_STATE:
        addr_hit = 1'b1;
      default:
        addr_hit = 1'b0;
    endcase
  end
  assign PREADY = 1'b1;
  assign PSLVERR = apb_access && (!addr_hit || logic_rst); // R07
  assign PRDATA = st_ff.rdata; // R16

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    logic wr;
    logic rd_status;
    logic clear_all;
    wr = 1'b0;
    rd_status = 1'b0;
    clear_all = 1'b0;
    nxt_st = st_ff;
    // synchronisers; first stages feed only the second stages
    nxt_st.pg_meta = POWER_GOOD;
    nxt_st.pg_sync = st_ff.pg_meta;
    nxt_st.lp_n_meta = LOWPOWER_N;
    nxt_st.lp_n_sync = st_ff.lp_n_meta;
    nxt_st.en_meta = permit_both;
    nxt_st.en_sync = st_ff.en_meta; // R17
    // comparator levels are registered each cycle
    nxt_st.level = PHASE_ABOVE_HALF; // R08
    // bus access, valid also while permits are low
    wr = apb_access && PWRITE && addr_hit && !logic_rst; // R02 R07 R15
    rd_status = apb_access && !PWRITE && !logic_rst && (PADDR == OFS_FAULT_STATUS);
    clear_all = rd_status;
    if (wr)
    begin
      unique case (PADDR)
        OFS_CONFIG:
        begin
          nxt_st.dt_bypass = PWDATA[CFG_DT_BYPASS_BIT]; // R13
          nxt_st.overlap_allow = PWDATA[CFG_OVERLAP_BIT]; // R13
          nxt_st.dead_cycles = PWDATA[CFG_DEAD_LSB +: DEAD_W];
        end
        OFS_SUPPRESS_LO:
          nxt_st.fault_suppress_lo = PWDATA[HALF_FAULTS-1:0]; // R12
        OFS_SUPPRESS_HI:
          nxt_st.fault_suppress_hi = PWDATA[HALF_FAULTS-1:0]; // R12
        OFS_COMMAND:
          clear_all = PWDATA[CMD_CLEAR_INT_BIT]; // R11
        default:
          nxt_st.dt_bypass = st_ff.dt_bypass;
      endcase
    end
    // sticky faults: clear first so a same-cycle event still sets
    if (clear_all)
      nxt_st.fault_status = '0; // R11
    nxt_st.fault_status = nxt_st.fault_status | FAULT_IN; // R11
    // interrupt held while any unmasked fault stays latched
    nxt_st.irq = |(nxt_st.fault_status & ~fault_mask); // R11 R12
    // read data captured in the setup phase
    if (apb_setup && !PWRITE)
    begin
      nxt_st.rdata = '0;
      unique case (PADDR)
        OFS_CONFIG:
        begin
          nxt_st.rdata[CFG_DT_BYPASS_BIT] = st_ff.dt_bypass;
          nxt_st.rdata[CFG_OVERLAP_BIT] = st_ff.overlap_allow;
          nxt_st.rdata[CFG_DEAD_LSB +: DEAD_W] = st_ff.dead_cycles;
        end
        OFS_FAULT_STATUS:
          nxt_st.rdata[NUM_FAULTS-1:0] = st_ff.fault_status | FAULT_IN;
        OFS_SUPPRESS_LO:
          nxt_st.rdata[HALF_FAULTS-1:0] = st_ff.fault_suppress_lo;
        OFS_SUPPRESS_HI:
          nxt_st.rdata[HALF_FAULTS-1:0] = st_ff.fault_suppress_hi;
        OFS_STATE:
        begin
          nxt_st.rdata[ST_LEVEL_LSB +: NUM_PHASES] = st_ff.level;
          nxt_st.rdata[ST_BOOT_LSB +: NUM_PHASES] = boot_ready;
          nxt_st.rdata[ST_ENABLED_BIT] = st_ff.en_sync;
          nxt_st.rdata[ST_IRQ_BIT] = st_ff.irq;
        end
        default:
          nxt_st.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register; supply synchronisers survive the power and low-power reset, not RST
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      st_ff <= '0;
      st_ff.dead_cycles <= DEAD_RESET;
      st_ff.fault_suppress_lo <= SUPPRESS_RESET;
      st_ff.fault_suppress_hi <= SUPPRESS_RESET;
    end
    else if (!powered)
    begin
      // logic held in reset, supply sampling continues
      st_ff <= '0; // R06 R07
      st_ff.pg_meta <= nxt_st.pg_meta;
      st_ff.pg_sync <= nxt_st.pg_sync;
      st_ff.lp_n_meta <= nxt_st.lp_n_meta;
      st_ff.lp_n_sync <= nxt_st.lp_n_sync;
      st_ff.level <= nxt_st.level;
      st_ff.dead_cycles <= DEAD_RESET;
      st_ff.fault_suppress_lo <= SUPPRESS_RESET;
      st_ff.fault_suppress_hi <= SUPPRESS_RESET;
    end
    else
      st_ff <= nxt_st;
  end

endmodule

/* verification/tpgcl_asserts.sv */
// port-level assertions for the gate control logic
`timescale 1ns/1ps
module tpgcl_asserts
(
  // clock, reset, supplies
  input wire logic MCLK,
  input wire logic RST,
  input wire logic POWER_GOOD,
  input wire logic LOWPOWER_N,
  // permits, commands, sense
  input wire logic DRIVE_PERMIT_FIRST,
  input wire logic DRIVE_PERMIT_SECOND,
  input wire logic HIGH_CMD_A_N,
  input wire logic [tpgcl_pkg::NUM_PHASES-1:0] PHASE_ABOVE_HALF,
  input wire logic [tpgcl_pkg::NUM_FAULTS-1:0] FAULT_IN,
  // bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [tpgcl_pkg::ADDR_W-1:0] PADDR,
  input wire logic [tpgcl_pkg::DATA_W-1:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // outputs
  input wire logic [tpgcl_pkg::NUM_PHASES-1:0] GATE_HIGH,
  input wire logic [tpgcl_pkg::NUM_PHASES-1:0] GATE_LOW,
  input wire logic GATE_OE,
  input wire logic GATE_WEAK_PULLDOWN,
  input wire logic BIAS_EN,
  input wire logic PHASE_LEVEL_A,
  input wire logic PHASE_LEVEL_B,
  input wire logic PHASE_LEVEL_C,
  input wire logic FAULT_IRQ
);
  import tpgcl_pkg::*;
  logic [2:0] up_ff;
  logic ovl_ff;
  logic [7:0] sup_ff;
  logic wr;
  // ----------------------------------------
  // shadows of run time, overlap and masks
  // ----------------------------------------
  assign wr = PSEL && PENABLE && PWRITE && PREADY && !PSLVERR;
  always_ff @(posedge MCLK)
  begin
    if (RST || !LOWPOWER_N || !POWER_GOOD)
    begin
      up_ff <= 3'h0;
      ovl_ff <= 1'b0;
      sup_ff <= 8'h00;
    end
    else
    begin
      up_ff <= (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
      if (wr && PADDR == OFS_CONFIG)
        ovl_ff <= PWDATA[CFG_OVERLAP_BIT];
      if (wr && PADDR == OFS_SUPPRESS_LO)
        sup_ff[3:0] <= PWDATA[3:0];
      if (wr && PADDR == OFS_SUPPRESS_HI)
        sup_ff[7:4] <= PWDATA[3:0];
    end
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  sequence s_lp_long;
    !LOWPOWER_N [*4];
  endsequence
  sequence s_pg_low;
    !POWER_GOOD [*4];
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_PERMIT: assert property (!(DRIVE_PERMIT_FIRST && DRIVE_PERMIT_SECOND) |->
    GATE_HIGH == 3'h0 && GATE_LOW == 3'h0) else $error("gate on without permits");
  AST_LP_GATES: assert property (!LOWPOWER_N |-> (GATE_HIGH | GATE_LOW) == 3'h0)
    else $error("gate on in low power");
  AST_LP_BIAS: assert property (s_lp_long |-> !BIAS_EN && GATE_WEAK_PULLDOWN)
    else $error("bias or pulldown wrong in low power");
  AST_LP_RESET: assert property (!LOWPOWER_N [*8] |-> !FAULT_IRQ &&
    (PSLVERR || !(PSEL && PENABLE))) else $error("logic not reset in time");
  AST_POR_OE: assert property (s_pg_low |-> !GATE_OE)
    else $error("gates driven below supply threshold");
  AST_LEVEL: assert property (up_ff > 3'h4 |->
    {PHASE_LEVEL_C, PHASE_LEVEL_B, PHASE_LEVEL_A} == $past(PHASE_ABOVE_HALF))
    else $error("phase level mismatch");
  AST_HI_IDLE: assert property (HIGH_CMD_A_N [*4] |-> !GATE_HIGH[0])
    else $error("high side on while command idle");
  AST_CROSS: assert property (!ovl_ff |-> (GATE_HIGH & GATE_LOW) == 3'h0)
    else $error("both sides of a phase on");
  AST_IRQ_SET: assert property (up_ff > 3'h4 && (FAULT_IN & ~sup_ff) != 8'h00 |=> FAULT_IRQ)
    else $error("fault did not raise interrupt");
  AST_IRQ_HOLD: assert property (FAULT_IRQ && !(PSEL && PENABLE) && $stable(sup_ff) &&
    up_ff > 3'h4 |=> FAULT_IRQ) else $error("interrupt dropped without clear");
  AST_MASK: assert property (up_ff > 3'h4 && !FAULT_IRQ && !(PSEL && PENABLE) &&
    $stable(sup_ff) && (FAULT_IN & ~sup_ff) == 8'h00 |=> !FAULT_IRQ)
    else $error("suppressed fault raised irq");
endmodule
bind tpgcl_top tpgcl_asserts tpgcl_asserts_i (.*);

/* verification/tpgcl_host.sv */
// host model: bus master and phase command driver
`timescale 1ns/1ps
module tpgcl_host
(
  // clock and bus answer
  input wire logic mclk,
  input wire logic [tpgcl_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // bus request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [tpgcl_pkg::ADDR_W-1:0] paddr,
  output logic [tpgcl_pkg::DATA_W-1:0] pwdata,
  // phase commands and permits
  output logic [2:0] hi_n,
  output logic [2:0] lo,
  output logic [1:0] en
);
  import tpgcl_pkg::*;
  // idle bus, commands off, permits on
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    hi_n = 3'h7;
    lo = 3'h0;
    en = 2'h3;
  end
  // one transfer, called just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // commands and permits, all three driven together
  task automatic pins(input logic [2:0] h, input logic [2:0] l, input logic [1:0] p);
    hi_n <= h;
    lo <= l;
    en <= p;
  endtask
endmodule

/* verification/tb_top.sv */
// self-checking bench for the gate control logic
`timescale 1ns/1ps
module tb_top;
  import tpgcl_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic pwr_good = 1'b1;
  logic lp_n = 1'b1;
  logic [2:0] above = 3'h0;
  logic [7:0] fault = 8'h00;
  logic psel, penable, pwrite, pready, pslverr, goe, wpd, bias, pla, plb, plc, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] hn, lo, gh, gl;
  logic [1:0] en;
  int err_count = 0;
  int checked = 0;
  // 125 MHz clock
  always #4 mclk = ~mclk;
  tpgcl_host tpgcl_host_i (.mclk(mclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .hi_n(hn), .lo(lo), .en(en));
  tpgcl_top tpgcl_top_i (.MCLK(mclk), .RST(rst), .POWER_GOOD(pwr_good), .LOWPOWER_N(lp_n),
    .DRIVE_PERMIT_FIRST(en[0]), .DRIVE_PERMIT_SECOND(en[1]), .HIGH_CMD_A_N(hn[0]),
    .LOW_CMD_A(lo[0]), .HIGH_CMD_B_N(hn[1]), .LOW_CMD_B(lo[1]), .HIGH_CMD_C_N(hn[2]),
    .LOW_CMD_C(lo[2]), .PHASE_ABOVE_HALF(above), .FAULT_IN(fault), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .GATE_HIGH(gh), .GATE_LOW(gl), .GATE_OE(goe),
    .GATE_WEAK_PULLDOWN(wpd), .BIAS_EN(bias), .PHASE_LEVEL_A(pla), .PHASE_LEVEL_B(plb),
    .PHASE_LEVEL_C(plc), .FAULT_IRQ(irq));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    tpgcl_host_i.apb(1'b0, a, 32'h0, rd, er);
    chk(nm, e, rd);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdc(OFS_CONFIG, 32'h00001000, "config");
    rdc(OFS_SUPPRESS_HI, 32'h0, "suppress_hi");
    tpgcl_host_i.apb(1'b0, 8'h18, 32'h0, rd, er);
    chk("unmapped_err", 32'h1, {31'h0, er});
    $display("t_regs done");
  endtask
  task automatic t_permit;
    tpgcl_host_i.pins(3'h7, 3'h1, 2'h3);
    cyc(6);
    chk("low_on", 32'h1, {29'h0, gl});
    tpgcl_host_i.pins(3'h7, 3'h1, 2'h1);
    #1;
    chk("forced_off", 32'h0, {26'h0, gh, gl});
    @(posedge mclk);
    tpgcl_host_i.pins(3'h7, 3'h0, 2'h1);
    rdc(OFS_CONFIG, 32'h00001000, "cfg_disabled");
    tpgcl_host_i.pins(3'h7, 3'h0, 2'h3);
    cyc(4);
    $display("t_permit done");
  endtask
  task automatic t_boot;
    tpgcl_host_i.pins(3'h6, 3'h0, 2'h3);
    cyc(10);
    chk("hs_no_boot", 32'h0, {29'h0, gh});
    tpgcl_host_i.pins(3'h7, 3'h1, 2'h3);
    cyc(5);
    tpgcl_host_i.pins(3'h6, 3'h0, 2'h3);
    cyc(8);
    chk("dead_wait", 32'h0, {29'h0, gh});
    cyc(20);
    chk("hs_on", 32'h1, {29'h0, gh});
    rdc(OFS_STATE, 32'h00000048, "state_boot");
    tpgcl_host_i.pins(3'h7, 3'h0, 2'h3);
    cyc(6);
    chk("hs_idle", 32'h0, {29'h0, gh});
    $display("t_boot done");
  endtask
  task automatic t_cross;
    tpgcl_host_i.pins(3'h5, 3'h2, 2'h3);
    cyc(30);
    chk("interlock", 32'h0, {26'h0, gh, gl});
    tpgcl_host_i.pins(3'h7, 3'h0, 2'h3);
    tpgcl_host_i.apb(1'b1, OFS_CONFIG, 32'h00001003, rd, er);
    tpgcl_host_i.pins(3'h5, 3'h2, 2'h3);
    cyc(30);
    chk("overlap", 32'h12, {26'h0, gh, gl});
    tpgcl_host_i.pins(3'h7, 3'h0, 2'h3);
    cyc(6);
    tpgcl_host_i.apb(1'b1, OFS_CONFIG, 32'h00001000, rd, er);
    $display("t_cross done");
  endtask
  task automatic t_irq;
    fault <= 8'h01;
    cyc(1);
    fault <= 8'h00;
    cyc(5);
    chk("irq_held", 32'h1, {31'h0, irq});
    tpgcl_host_i.apb(1'b1, OFS_COMMAND, 32'h1, rd, er);
    chk("irq_clear", 32'h0, {31'h0, irq});
    tpgcl_host_i.apb(1'b1, OFS_SUPPRESS_HI, 32'h1, rd, er);
    fault <= 8'h30;
    cyc(1);
    fault <= 8'h00;
    cyc(3);
    chk("irq_part", 32'h1, {31'h0, irq});
    rdc(OFS_FAULT_STATUS, 32'h30, "status");
    chk("irq_read_clr", 32'h0, {31'h0, irq});
    tpgcl_host_i.apb(1'b1, OFS_SUPPRESS_LO, 32'hF, rd, er);
    fault <= 8'h1F;
    cyc(1);
    fault <= 8'h00;
    cyc(3);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdc(OFS_FAULT_STATUS, 32'h1F, "status_masked");
    tpgcl_host_i.apb(1'b1, OFS_SUPPRESS_LO, 32'h0, rd, er);
    tpgcl_host_i.apb(1'b1, OFS_SUPPRESS_HI, 32'h0, rd, er);
    $display("t_irq done");
  endtask
  task automatic t_level;
    for (int v = 0; v < 8; v++)
    begin
      above <= 3'(v);
      cyc(3);
      chk("level", 32'(v), {29'h0, plc, plb, pla});
    end
    $display("t_level done");
  endtask
  task automatic t_power;
    tpgcl_host_i.apb(1'b1, OFS_CONFIG, 32'h00001001, rd, er);
    tpgcl_host_i.pins(3'h7, 3'h1, 2'h3);
    cyc(6);
    lp_n <= 1'b0;
    #1;
    chk("lp_gates", 32'h0, {29'h0, gl});
    @(posedge mclk);
    tpgcl_host_i.pins(3'h7, 3'h0, 2'h3);
    cyc(10);
    chk("lp_bias", 32'h1, {30'h0, bias, wpd});
    tpgcl_host_i.apb(1'b0, OFS_CONFIG, 32'h0, rd, er);
    chk("lp_refuse", 32'h1, {31'h0, er});
    lp_n <= 1'b1;
    cyc(4);
    rdc(OFS_CONFIG, 32'h00001000, "cfg_after_lp");
    pwr_good <= 1'b0;
    cyc(5);
    chk("por_oe", 32'h0, {31'h0, goe});
    tpgcl_host_i.apb(1'b1, OFS_CONFIG, 32'h0, rd, er);
    chk("por_refuse", 32'h1, {31'h0, er});
    pwr_good <= 1'b1;
    cyc(4);
    chk("por_oe_back", 32'h1, {31'h0, goe});
    $display("t_power done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    cyc(20);
    rst <= 1'b0;
    cyc(4);
    t_regs;
    t_permit;
    t_boot;
    t_cross;
    t_irq;
    t_level;
    t_power;
    complete_run;
  end
  initial
  begin
    #200000;
    err_count++;
    complete_run;
  end
endmodule
